//--- pkg/ulm_pkg.sv
// Package with register map, field layout and shared types of the line control block
package ulm_pkg;
  localparam logic [7:0] ADR_DATA   = 8'h00;
  localparam logic [7:0] ADR_DIVHI  = 8'h04;
  localparam logic [7:0] ADR_QUEUE  = 8'h08;
  localparam logic [7:0] ADR_LINE   = 8'h0c;
  localparam logic [7:0] ADR_MODEM  = 8'h10;
  localparam logic [7:0] ADR_ENH    = 8'h14;
  localparam logic [7:0] ADR_FEAT   = 8'h18;
  localparam logic [7:0] ADR_TRIG   = 8'h1c;
  localparam logic [7:0] ADR_STAT   = 8'h20;

  localparam int Q_EN     = 0;
  localparam int Q_RXCLR  = 1;
  localparam int Q_TXCLR  = 2;
  localparam int Q_DMA    = 3;
  localparam int Q_TXSEL  = 4;
  localparam int Q_RXSEL  = 6;
  localparam int L_STOP   = 2;
  localparam int L_PEN    = 3;
  localparam int L_PEVEN  = 4;
  localparam int L_PFORCE = 5;
  localparam int L_BREAK  = 6;
  localparam int L_DIV    = 7;
  localparam int M_DTR    = 0;
  localparam int M_RTS    = 1;
  localparam int M_AUX1   = 2;
  localparam int M_AUX2   = 3;
  localparam int M_LOOP   = 4;
  localparam int M_ANY    = 5;
  localparam int M_IR     = 6;
  localparam int E_ENH    = 4;
  localparam int E_ARTS   = 6;
  localparam int F_TBL    = 4;
  localparam int F_TRGTX  = 7;

  localparam logic [7:0] LINE_RST  = 8'h00;
  localparam logic [7:0] MODEM_RST = 8'h00;
  localparam logic [7:0] REG_RST   = 8'h00;
  localparam logic [7:0] DIV_RST   = 8'h00;
  localparam logic [7:0] TRG_RST   = 8'h01;

  // Cycles a received infrared pulse stretches into a zero at 25 MHz
  localparam logic [3:0] IR_HOLD   = 4'h8;

  typedef enum logic [1:0] {
    ULM_TBL_A = 2'b00,
    ULM_TBL_B = 2'b01,
    ULM_TBL_C = 2'b10,
    ULM_TBL_P = 2'b11
  } ulm_tbl_t;

  typedef struct packed {
    logic [1:0] word_len;
    logic       stop_two;
    logic       stop_half;
    logic       par_en;
    logic       par_even;
    logic       par_forced;
    logic       par_bit;
  } ulm_fmt_t;

  typedef struct packed {
    logic       fifo_en;
    logic       dma_mode;
    logic       tx_clr;
    logic       rx_clr;
  } ulm_queue_t;
endpackage

//--- src/ulm_trig.sv
// Trigger level tables for receive and transmit queues
`timescale 1ns/1ps
`default_nettype none
module ulm_trig #(
  parameter int CW = 8
) (
  input  wire ulm_pkg::ulm_tbl_t tbl,
  input  wire logic [1:0]        rx_sel,
  input  wire logic [1:0]        tx_sel,
  input  wire logic [CW-1:0]     prog_rx,
  input  wire logic [CW-1:0]     prog_tx,
  output logic [CW-1:0]          rx_lvl,
  output logic [CW-1:0]          tx_lvl
);
  import ulm_pkg::*;
  logic [7:0] rx_raw;
  logic [7:0] tx_raw;

  always_comb begin
    rx_raw = 8'h01;
    tx_raw = 8'h01;
    case (tbl)
      ULM_TBL_A: begin
        case (rx_sel)
          2'b00:   rx_raw = 8'h01;
          2'b01:   rx_raw = 8'h04;
          2'b10:   rx_raw = 8'h08;
          default: rx_raw = 8'h0e;
        endcase
        tx_raw = 8'h01;
      end
      ULM_TBL_B: begin
        case (rx_sel)
          2'b00:   rx_raw = 8'h08;
          2'b01:   rx_raw = 8'h10;
          2'b10:   rx_raw = 8'h18;
          default: rx_raw = 8'h1c;
        endcase
        case (tx_sel)
          2'b00:   tx_raw = 8'h10;
          2'b01:   tx_raw = 8'h08;
          2'b10:   tx_raw = 8'h18;
          default: tx_raw = 8'h1e;
        endcase
      end
      ULM_TBL_C: begin
        case (rx_sel)
          2'b00:   rx_raw = 8'h08;
          2'b01:   rx_raw = 8'h10;
          2'b10:   rx_raw = 8'h38;
          default: rx_raw = 8'h3c;
        endcase
        case (tx_sel)
          2'b00:   tx_raw = 8'h08;
          2'b01:   tx_raw = 8'h10;
          2'b10:   tx_raw = 8'h20;
          default: tx_raw = 8'h38;
        endcase
      end
      default: begin
        rx_raw = 8'h00;
        tx_raw = 8'h00;
      end
    endcase
  end

  // Table select is a single field, so both sides always share one table
  assign rx_lvl = (tbl == ULM_TBL_P) ? prog_rx : CW'(rx_raw);
  assign tx_lvl = (tbl == ULM_TBL_P) ? prog_tx : CW'(tx_raw);
endmodule
`default_nettype wire

//--- src/ulm_ctrl.sv
// Queue, line format and modem control for one serial channel, Wishbone slave
// Overview of operation
// - Transmit queue clear pulses, then self-clears
// - DMA select changes ready pin behaviour
// - Transmit request below level or empty
// - Receive request when count reaches level
// - One trigger table serves both directions
// - Fixed trigger level tables A, B, C
// - Table 11 uses programmable trigger register
// - Word length five to eight bits
// - Stop bits one, one-half or two
// - Parity enable adds and checks parity
// - Parity type odd or even
// - Forced parity is fixed mark or space
// - Break holds transmit line at space
// - Divisor enable redirects data addresses
// - Terminal ready pin is inverse bit
// - Request to send inverse bit or auto
// - Aux one feeds looped bell state
// - Interrupt enable drives outputs and aux two
// - Loopback connects line internally
// - Any character resumes halted transmitter
// - Infrared coding, transmit rests low
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl #(
  parameter int CW = 8
) (
  input  wire logic                clk,
  input  wire logic                rstn,
  input  wire logic                ce,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic [31:0]              wb_dat_o,
  output logic                     wb_ack_o,
  input  wire logic [CW-1:0]       tx_count,
  input  wire logic [CW-1:0]       rx_count,
  input  wire logic [7:0]          rx_data,
  output logic                     rx_data_rd,
  output logic                     tx_data_wr,
  output logic [7:0]               tx_data,
  output ulm_pkg::ulm_queue_t      queue,
  output ulm_pkg::ulm_fmt_t        line_fmt,
  output logic [15:0]              divisor,
  output logic                     tx_req,
  output logic                     rx_req,
  output logic                     tx_ready_pin_n,
  output logic                     rx_ready_pin_n,
  input  wire logic                tx_bit,
  input  wire logic                ir_pulse_win,
  output logic                     tx_pin,
  input  wire logic                rx_pin,
  output logic                     rx_line,
  output logic                     loop_mode,
  input  wire logic                modem_bell_in,
  output logic                     modem_bell_state,
  output logic                     dtr_pin_n,
  output logic                     rts_pin_n,
  input  wire logic                auto_rts_n,
  output logic                     aux_out_two_n,
  output logic                     int_oe_n,
  input  wire logic                rx_char_done,
  input  wire logic                rx_char_flow,
  input  wire logic                tx_halted,
  output logic                     tx_resume,
  output logic                     rx_char_keep
);
  import ulm_pkg::*;

  logic [7:0]    line_r;
  logic [7:0]    modem_r;
  logic [7:0]    enh_r;
  logic [7:0]    feat_r;
  logic [7:0]    dll_r;
  logic [7:0]    dlm_r;
  logic [CW-1:0] trg_rx_r;
  logic [CW-1:0] trg_tx_r;
  logic          fifo_en_r;
  logic          dma_r;
  logic [1:0]    tx_sel_r;
  logic [1:0]    rx_sel_r;
  logic          tx_clr_r;
  logic          rx_clr_r;
  logic          ack_r;
  logic [31:0]   dat_r;
  logic          rd_r;
  logic          wr_r;
  logic [7:0]    txd_r;
  logic [CW-1:0] tx_prev_r;
  logic          above_r;
  logic          tx_req_r;
  logic          rx_req_r;
  logic [1:0]    rx_sync_r;
  logic [1:0]    bell_sync_r;
  logic [3:0]    ir_cnt_r;
  logic          rx_line_r;
  logic          tx_pin_r;
  logic          resume_r;
  logic          keep_r;
  logic [CW-1:0] rx_lvl;
  logic [CW-1:0] tx_lvl;

  // Bus decode: a request is served once, at the edge that raises ack
  wire        req     = wb_cyc_i & wb_stb_i & ~ack_r;
  wire        wr      = req & wb_we_i & wb_sel_i[0];
  wire        rd      = req & ~wb_we_i;
  wire [7:0]  wd      = wb_dat_i[7:0];
  wire        dlab    = line_r[L_DIV];
  wire        hit_dat = (wb_adr_i == ADR_DATA);
  wire        hit_dhi = (wb_adr_i == ADR_DIVHI);
  wire        wr_dll  = wr & hit_dat & dlab;
  wire        wr_dlm  = wr & hit_dhi & dlab;
  wire        wr_thr  = wr & hit_dat & ~dlab;
  wire        rd_rhr  = rd & hit_dat & ~dlab;
  wire        wr_q    = wr & (wb_adr_i == ADR_QUEUE);
  wire        wr_q_ok = wr_q & wd[Q_EN];
  wire        wr_line = wr & (wb_adr_i == ADR_LINE);
  wire        wr_mdm  = wr & (wb_adr_i == ADR_MODEM);
  wire        wr_enh  = wr & (wb_adr_i == ADR_ENH);
  wire        wr_feat = wr & (wb_adr_i == ADR_FEAT);
  wire        wr_trg  = wr & (wb_adr_i == ADR_TRIG);
  wire        loop    = modem_r[M_LOOP];
  wire        ir_on   = modem_r[M_IR];
  wire        sw_flow = |enh_r[3:0];

  // Read selection; unmapped addresses answer with zero
  wire [7:0] stat_v  = {fifo_en_r, fifo_en_r, 4'h0, rx_req_r, tx_req_r};
  wire [7:0] dat_v   = dlab ? dll_r : rx_data;
  wire [7:0] dhi_v   = dlab ? dlm_r : 8'h00;
  wire [7:0] rdata   = hit_dat                    ? dat_v :
                       hit_dhi                    ? dhi_v :
                       (wb_adr_i == ADR_LINE)     ? line_r :
                       (wb_adr_i == ADR_MODEM)    ? modem_r :
                       (wb_adr_i == ADR_ENH)      ? enh_r :
                       (wb_adr_i == ADR_FEAT)     ? feat_r :
                       (wb_adr_i == ADR_TRIG)     ? 8'(feat_r[F_TRGTX] ? trg_tx_r : trg_rx_r) :
                       (wb_adr_i == ADR_STAT)     ? stat_v : 8'h00;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
      rd_r  <= 1'b0;
      wr_r  <= 1'b0;
      txd_r <= 8'h00;
    end else if (ce) begin
      ack_r <= req;
      rd_r  <= rd_rhr;
      wr_r  <= wr_thr;
      if (rd)
        dat_r <= {24'h00_0000, rdata};
      if (wr_thr)
        txd_r <= wd;
    end
  end

  // Format and modem registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      line_r  <= LINE_RST;
      modem_r <= MODEM_RST;
      enh_r   <= REG_RST;
      feat_r  <= REG_RST;
      dll_r   <= DIV_RST;
      dlm_r   <= DIV_RST;
    end else if (ce) begin
      if (wr_line)
        line_r <= wd;
      if (wr_mdm)
        modem_r <= {1'b0, wd[6:0]};
      if (wr_enh)
        enh_r <= wd;
      if (wr_feat)
        feat_r <= wd;
      if (wr_dll)
        dll_r <= wd;
      if (wr_dlm)
        dlm_r <= wd;
    end
  end

  // Queue control; clear bits act only alongside the enable bit
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      fifo_en_r <= 1'b0;
      dma_r     <= 1'b0;
      tx_sel_r  <= 2'b00;
      rx_sel_r  <= 2'b00;
      tx_clr_r  <= 1'b0;
      rx_clr_r  <= 1'b0;
      trg_rx_r  <= CW'(TRG_RST);
      trg_tx_r  <= CW'(TRG_RST);
    end else if (ce) begin
      tx_clr_r <= wr_q_ok & wd[Q_TXCLR];
      rx_clr_r <= wr_q_ok & wd[Q_RXCLR];
      if (wr_q)
        fifo_en_r <= wd[Q_EN];
      if (wr_q_ok) begin
        dma_r    <= wd[Q_DMA];
        rx_sel_r <= wd[Q_RXSEL +: 2];
        // Transmit select stays put unless enhanced mode is on
        if (enh_r[E_ENH])
          tx_sel_r <= wd[Q_TXSEL +: 2];
      end
      if (wr_trg & ~feat_r[F_TRGTX])
        trg_rx_r <= CW'(wd);
      if (wr_trg & feat_r[F_TRGTX])
        trg_tx_r <= CW'(wd);
    end
  end

  ulm_trig #(
    .CW (CW)
  ) u_trig (
    .tbl     (ulm_tbl_t'(feat_r[F_TBL +: 2])),
    .rx_sel  (rx_sel_r),
    .tx_sel  (tx_sel_r),
    .prog_rx (trg_rx_r),
    .prog_tx (trg_tx_r),
    .rx_lvl  (rx_lvl),
    .tx_lvl  (tx_lvl)
  );

  // Transmit request: falling under the level, or draining to empty after a
  // reload that never rose above the level. Set beats the clear by a data write.
  wire tx_below = (tx_prev_r >= tx_lvl) & (tx_count < tx_lvl);
  wire tx_empty = (tx_prev_r != '0) & (tx_count == '0) & ~above_r;
  wire tx_set   = fifo_en_r ? (tx_below | tx_empty) : ((tx_prev_r != '0) & (tx_count == '0));
  wire rx_hit   = fifo_en_r ? (rx_count >= rx_lvl) : (rx_count != '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_prev_r <= '0;
      above_r   <= 1'b0;
      tx_req_r  <= 1'b0;
      rx_req_r  <= 1'b0;
    end else if (ce) begin
      tx_prev_r <= tx_count;
      if (tx_count > tx_lvl)
        above_r <= 1'b1;
      else if (tx_count == '0)
        above_r <= 1'b0;
      if (tx_set)
        tx_req_r <= 1'b1;
      else if (wr_thr)
        tx_req_r <= 1'b0;
      rx_req_r <= rx_hit;
    end
  end

  // Line side: pins pass two flops; infrared pulses stretch into a zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_sync_r   <= 2'b11;
      bell_sync_r <= 2'b11;
      ir_cnt_r    <= 4'h0;
      rx_line_r   <= 1'b1;
      tx_pin_r    <= 1'b1;
      resume_r    <= 1'b0;
      keep_r      <= 1'b0;
    end else if (ce) begin
      rx_sync_r   <= {rx_sync_r[0], rx_pin};
      bell_sync_r <= {bell_sync_r[0], modem_bell_in};
      if (ir_on & rx_sync_r[1])
        ir_cnt_r <= IR_HOLD;
      else if (ir_cnt_r != 4'h0)
        ir_cnt_r <= ir_cnt_r - 4'h1;
      if (loop)
        rx_line_r <= tx_bit;
      else if (ir_on)
        rx_line_r <= (ir_cnt_r == 4'h0) & ~rx_sync_r[1];
      else
        rx_line_r <= rx_sync_r[1];
      if (line_r[L_BREAK])
        tx_pin_r <= 1'b0;
      else if (ir_on)
        tx_pin_r <= ~loop & ~tx_bit & ir_pulse_win;
      else
        tx_pin_r <= loop | tx_bit;
      resume_r <= rx_char_done & modem_r[M_ANY] & tx_halted;
      keep_r   <= rx_char_done & ~(rx_char_flow & sw_flow);
    end
  end

  // Line format fields
  assign line_fmt.word_len   = line_r[1:0];
  assign line_fmt.stop_two   = line_r[L_STOP] & (line_r[1:0] != 2'b00);
  assign line_fmt.stop_half  = line_r[L_STOP] & (line_r[1:0] == 2'b00);
  assign line_fmt.par_en     = line_r[L_PEN];
  assign line_fmt.par_even   = line_r[L_PEVEN];
  assign line_fmt.par_forced = line_r[L_PEN] & line_r[L_PFORCE];
  assign line_fmt.par_bit    = ~line_r[L_PEVEN];

  assign queue.fifo_en  = fifo_en_r;
  assign queue.dma_mode = dma_r;
  assign queue.tx_clr   = tx_clr_r;
  assign queue.rx_clr   = rx_clr_r;

  // Ready pins: single-character mode versus block transfer mode
  wire txr_act = dma_r ? (tx_count < tx_lvl) : (tx_count == '0);
  wire rxr_act = dma_r ? rx_hit : (rx_count != '0);
  assign tx_ready_pin_n = ~(fifo_en_r ? txr_act : (tx_count == '0));
  assign rx_ready_pin_n = ~(fifo_en_r ? rxr_act : (rx_count != '0));

  // DTR, RTS and aux two pins go inactive in loopback, int_oe_n does not; aux one feeds the bell state
  assign dtr_pin_n        = loop | ~modem_r[M_DTR];
  assign rts_pin_n        = loop | (enh_r[E_ARTS] ? auto_rts_n : ~modem_r[M_RTS]);
  assign aux_out_two_n    = loop | ~modem_r[M_AUX2];
  assign int_oe_n         = ~modem_r[M_AUX2];
  assign modem_bell_state = loop ? modem_r[M_AUX1] : ~bell_sync_r[1];
  assign loop_mode        = loop;

  assign divisor      = {dlm_r, dll_r};
  assign wb_ack_o     = ack_r;
  assign wb_dat_o     = dat_r;
  assign rx_data_rd   = rd_r;
  assign tx_data_wr   = wr_r;
  assign tx_data      = txd_r;
  assign tx_req       = tx_req_r;
  assign rx_req       = rx_req_r;
  assign tx_pin       = tx_pin_r;
  assign rx_line      = rx_line_r;
  assign tx_resume    = resume_r;
  assign rx_char_keep = keep_r;
endmodule
`default_nettype wire

//--- tb/ulm_line_model.sv
// Remote serial device: sends framed bytes on the receive pin and drives the bell pin
`timescale 1ns/1ps
`default_nettype none
module ulm_line_model (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [7:0] byte_in,
  input  wire logic       bell,
  output logic            rx_pin,
  output logic            modem_bell_in
);
  logic [9:0] sh_r = 10'h3ff;
  // One clock per bit keeps frames short; the line rests at mark between frames
  always @(posedge clk) begin
    if (go)
      sh_r <= {1'b1, byte_in, 1'b0};
    else
      sh_r <= {1'b1, sh_r[9:1]};
  end
  assign rx_pin        = sh_r[0];
  assign modem_bell_in = !bell;
endmodule
`default_nettype wire

//--- tb/ulm_ctrl_assertions.sv
// Concurrent checks on the ports of the line control block
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl_assertions #(
  parameter int CW = 8
) (
  input wire logic            clk,
  input wire logic            rstn,
  input wire logic            ce,
  input wire logic            wb_cyc_i,
  input wire logic            wb_stb_i,
  input wire logic            wb_we_i,
  input wire logic [7:0]      wb_adr_i,
  input wire logic [3:0]      wb_sel_i,
  input wire logic [31:0]     wb_dat_i,
  input wire logic [31:0]     wb_dat_o,
  input wire logic            wb_ack_o,
  input wire ulm_pkg::ulm_queue_t queue,
  input wire ulm_pkg::ulm_fmt_t   line_fmt,
  input wire logic [15:0]     divisor,
  input wire logic            tx_pin,
  input wire logic            dtr_pin_n,
  input wire logic            aux_out_two_n,
  input wire logic            int_oe_n,
  input wire logic            loop_mode
);
  import ulm_pkg::*;
  logic       tk, wr, brk_r, dlab_r;
  logic [7:0] d;
  assign tk = wb_cyc_i && wb_stb_i && !wb_ack_o && ce;
  assign wr = tk && wb_we_i && wb_sel_i[0];
  assign d  = wb_dat_i[7:0];
  // Shadow of the break and divisor bits, updated on the same edge as the design
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      brk_r  <= 1'b0;
      dlab_r <= 1'b0;
    end else if (wr && wb_adr_i == ADR_LINE) begin
      brk_r  <= d[L_BREAK];
      dlab_r <= d[L_DIV];
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ack_one_shot: assert property (tk |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack is not a single cycle after a request");
  a_txclr_pulse: assert property (
    wr && wb_adr_i == ADR_QUEUE && d[Q_EN] && d[Q_TXCLR] |=> queue.tx_clr ##1 !queue.tx_clr)
    else $error("transmit clear is not a one cycle pulse");
  a_queue_gated: assert property (
    wr && wb_adr_i == ADR_QUEUE && !d[Q_EN] |=> !queue.fifo_en && !queue.tx_clr
      && queue.dma_mode == $past(queue.dma_mode))
    else $error("queue bits taken without enable");
  a_dma_select: assert property (
    wr && wb_adr_i == ADR_QUEUE && d[Q_EN] |=> queue.dma_mode == $past(wb_dat_i[Q_DMA]))
    else $error("dma mode does not follow write");
  a_word_stop: assert property (
    wr && wb_adr_i == ADR_LINE |=> line_fmt.word_len == $past(wb_dat_i[1:0])
      && line_fmt.stop_half == ($past(wb_dat_i[2]) && $past(wb_dat_i[1:0]) == 2'b00)
      && line_fmt.stop_two == ($past(wb_dat_i[2]) && $past(wb_dat_i[1:0]) != 2'b00))
    else $error("word length or stop bits wrong");
  a_parity_type: assert property (
    wr && wb_adr_i == ADR_LINE && d[L_PEN] && !d[L_PFORCE] |=> line_fmt.par_en
      && !line_fmt.par_forced && line_fmt.par_even == $past(wb_dat_i[L_PEVEN]))
    else $error("parity type wrong");
  a_parity_forced: assert property (
    wr && wb_adr_i == ADR_LINE && d[L_PEN] && d[L_PFORCE] |=> line_fmt.par_forced
      && line_fmt.par_bit == !$past(wb_dat_i[L_PEVEN]))
    else $error("forced parity bit wrong");
  a_break_space: assert property ($past(brk_r) && brk_r |-> !tx_pin)
    else $error("transmit pin not at space during break");
  a_div_read: assert property (
    tk && !wb_we_i && wb_adr_i == ADR_DATA && dlab_r |=> wb_dat_o == {24'h0, divisor[7:0]})
    else $error("data address does not reach divisor");
  a_modem_pins: assert property (
    wr && wb_adr_i == ADR_MODEM && !d[M_LOOP] |=> dtr_pin_n == !$past(wb_dat_i[M_DTR])
      && aux_out_two_n == !$past(wb_dat_i[M_AUX2]) && int_oe_n == !$past(wb_dat_i[M_AUX2]))
    else $error("modem output pins wrong");
  a_loop_level: assert property (
    wr && wb_adr_i == ADR_MODEM |=> loop_mode == $past(wb_dat_i[M_LOOP]))
    else $error("loop mode does not follow write");
endmodule
bind ulm_ctrl ulm_ctrl_assertions #(.CW(CW)) u_chk (.clk(clk), .rstn(rstn), .ce(ce),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .queue(queue), .line_fmt(line_fmt), .divisor(divisor), .tx_pin(tx_pin),
  .dtr_pin_n(dtr_pin_n), .aux_out_two_n(aux_out_two_n), .int_oe_n(int_oe_n),
  .loop_mode(loop_mode));
`default_nettype wire

//--- tb/ulm_ctrl_tb.sv
// Self-checking bench for the line control block
`timescale 1ns/1ps
`default_nettype none
module ulm_ctrl_tb;
  import ulm_pkg::*;
  logic        clk, rstn, cyc, stb, we, ack, txb, go, bell, done, halt;
  logic        rxp, bell_n, txp, rxl, lpm, bst, dtr, rts, aux2, oe, rsm, rxreq;
  logic        rdr, twr, treq, trdy_n, rrdy_n, kp;
  logic [3:0]  sel;
  logic [7:0]  adr, rxd, rxc, byt, tdat, txc;
  // Fill levels for the transmit scenario and the expected {request, ready pins}
  int          tq [5] = '{9, 7, 0, 5, 0};
  logic [2:0]  te [5] = '{3'b011, 3'b101, 3'b001, 3'b001, 3'b101};
  logic [31:0] wdat, rdat, rv;
  logic [15:0] dv;
  ulm_queue_t  q, q_ack;
  ulm_fmt_t    fmt;
  int          mismatches, n_checks, lm, mm, lv;
  int          rxt [3][4] = '{'{1, 4, 8, 14}, '{8, 16, 24, 28}, '{8, 16, 56, 60}};

  ulm_ctrl u_ulm_ctrl (.clk(clk), .rstn(rstn), .ce(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .tx_count(txc), .rx_count(rxc), .rx_data(rxd), .rx_data_rd(rdr),
    .tx_data_wr(twr), .tx_data(tdat), .queue(q), .line_fmt(fmt), .divisor(dv), .tx_req(treq),
    .rx_req(rxreq), .tx_ready_pin_n(trdy_n), .rx_ready_pin_n(rrdy_n), .tx_bit(txb),
    .ir_pulse_win(1'b0),
    .tx_pin(txp), .rx_pin(rxp), .rx_line(rxl), .loop_mode(lpm), .modem_bell_in(bell_n),
    .modem_bell_state(bst), .dtr_pin_n(dtr), .rts_pin_n(rts), .auto_rts_n(1'b1),
    .aux_out_two_n(aux2), .int_oe_n(oe), .rx_char_done(done), .rx_char_flow(1'b0),
    .tx_halted(halt), .tx_resume(rsm), .rx_char_keep(kp));
  ulm_line_model u_ulm_line_model (.clk(clk), .go(go), .byte_in(byt), .bell(bell),
    .rx_pin(rxp), .modem_bell_in(bell_n));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Read data and queue state are taken at the edge that samples ack high
  // A missing ack is left to the watchdog, which ends the run
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, sel, wdat} <= {1'b1, 1'b1, w, a, 4'h1, 24'h0, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    rv = rdat;
    q_ack = q;
    {cyc, stb, we, sel} <= '0;
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // The whole run needs a few hundred cycles; 25000 cycles is a hang
  initial begin
    #1000000;
    mismatches++;
    tally_and_finish();
  end
  initial begin
    {cyc, stb, we, go, bell, done, halt, txb, rstn} = 9'h02;
    {sel, adr, wdat, rxd, rxc, byt, txc} = '0;
    void'($urandom(32'h1262));
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    bus(0, ADR_LINE, 0);
    chk(rv, LINE_RST);
    bus(0, ADR_MODEM, 0);
    chk(rv, MODEM_RST);
    chk({dtr, rts, aux2, oe, txp}, 5'h1f);
    bus(0, 8'h24, 0);
    chk(rv, 0);
    $display("test reset values done");
    repeat (8) begin
      lm = $urandom & 8'h3f;
      mm = $urandom & 8'hef;
      bus(1, ADR_LINE, 8'(lm));
      bus(1, ADR_MODEM, 8'(mm));
      bus(0, ADR_LINE, 0);
      chk(rv, lm);
      chk(fmt.word_len, lm & 3);
      chk({fmt.stop_two, fmt.stop_half}, {lm[2] && lm[1:0] != 0, lm[2] && lm[1:0] == 0});
      chk(fmt.par_en, lm[3]);
      if (lm[3]) chk({fmt.par_forced, fmt.par_even}, {lm[5], lm[4]});
      if (lm[3] && lm[5]) chk(fmt.par_bit, !lm[4]);
      chk({dtr, rts, aux2, oe}, {!mm[0], !mm[1], !mm[3], !mm[3]});
      bus(0, ADR_MODEM, 0);
      chk(rv, mm & 8'h6f);
    end
    $display("test format and modem done");
    bus(1, ADR_MODEM, 0);
    bus(1, ADR_LINE, 8'h43);
    repeat (3) @(posedge clk);
    chk(txp, 0);
    bus(1, ADR_LINE, 8'h03);
    repeat (3) @(posedge clk);
    chk(txp, 1);
    bus(1, ADR_MODEM, 8'h40);
    repeat (3) @(posedge clk);
    chk(txp, 0);
    $display("test break and infrared done");
    lm = $urandom;
    bus(1, ADR_LINE, 8'h83);
    bus(1, ADR_DATA, lm[7:0]);
    bus(1, ADR_DIVHI, lm[15:8]);
    chk(dv, lm[15:0]);
    bus(0, ADR_DATA, 0);
    chk(rv, lm[7:0]);
    bus(1, ADR_LINE, 8'h03);
    rxd <= 8'($urandom);
    bus(0, ADR_DATA, 0);
    chk(rv, rxd);
    chk(rdr, 1);
    $display("test divisor done");
    bus(1, ADR_QUEUE, 8'h0d);
    chk({q_ack.fifo_en, q_ack.dma_mode, q_ack.tx_clr}, 3'b111);
    @(posedge clk);
    chk(q.tx_clr, 0);
    bus(1, ADR_QUEUE, 8'h04);
    chk({q_ack.fifo_en, q_ack.dma_mode, q_ack.tx_clr}, 3'b010);
    $display("test queue control done");
    for (int t = 0; t < 4; t++)
      for (int s = 0; s < 4; s++) begin
        lv = (t == 3) ? 1 + $urandom % 100 : rxt[t % 3][s];
        bus(1, ADR_FEAT, 8'(t << 4));
        if (t == 3) bus(1, ADR_TRIG, 8'(lv));
        bus(1, ADR_QUEUE, 8'((s << 6) | 1));
        rxc <= 8'(lv - 1);
        repeat (3) @(posedge clk);
        chk(rxreq, 0);
        rxc <= 8'(lv);
        repeat (3) @(posedge clk);
        chk(rxreq, 1);
      end
    $display("test trigger levels done");
    rxc <= 8'h04;
    bus(1, ADR_ENH, 8'h10);
    bus(1, ADR_FEAT, 8'h10);
    bus(1, ADR_QUEUE, 8'h19);
    foreach (tq[i]) begin
      txc <= 8'(tq[i]);
      repeat (3) @(posedge clk);
      chk({treq, trdy_n, rrdy_n}, te[i]);
      if (i == 1) begin
        bus(1, ADR_DATA, 8'h5a);
        chk({twr, tdat, treq}, 10'h2b4);
      end
    end
    $display("test transmit request done");
    bus(1, ADR_MODEM, 0);
    bell <= 1'b1;
    byt <= 8'h00;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (5) @(posedge clk);
    chk({bst, rxl}, 2'b10);
    bus(1, ADR_MODEM, 8'h1f);
    chk({lpm, bst, dtr, rts, aux2}, 5'h1f);
    bus(1, ADR_MODEM, 8'h10);
    chk(bst, 0);
    txb <= 1'b0;
    repeat (3) @(posedge clk);
    chk({rxl, txp}, 2'b01);
    txb <= 1'b1;
    bell <= 1'b0;
    $display("test loopback done");
    halt <= 1'b1;
    for (int a = 0; a < 2; a++) begin
      bus(1, ADR_MODEM, 8'(a << 5));
      done <= 1'b1;
      @(posedge clk);
      done <= 1'b0;
      @(posedge clk);
      chk({rsm, kp}, {a[0], 1'b1});
    end
    $display("test resume done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
